//--- pmic_status_event_mask.sv
// Status, latched event flags, masks and interrupt pin driver
`timescale 1ns/1ns

module pmic_status_event_mask
	import pmic_status_pkg::*;
#(
	parameter int SHORT_LIMIT = pmic_status_pkg::SHORT_CYCLES
) (
	// Clock, reset, enable
	input logic mclk,
	input logic rst,
	input logic ce,
	// Register port from serial interface logic
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic reg_write,
	input logic reg_read,
	output logic [7:0] reg_rdata,
	// Mask defaults from one-time memory
	input logic [7:0] otp_top_mask_one,
	input logic otp_top_mask_two,
	input logic [7:0] otp_switcher_mask,
	// Analog monitor levels
	input logic power_good_output,
	input logic external_clock_invalid,
	input logic thermal_shutdown_state,
	input logic thermal_warning_state,
	input logic input_overvoltage_state,
	input logic switcher_b_enabled,
	input logic switcher_b_invalid_raw,
	input logic switcher_b_limit_raw,
	input logic switcher_b_short_raw,
	input logic switcher_a_enabled,
	input logic switcher_a_invalid_raw,
	input logic switcher_a_limit_raw,
	input logic switcher_a_short_raw,
	input logic linear_b_enabled,
	input logic linear_b_invalid_raw,
	input logic linear_b_limit_raw,
	input logic linear_b_short_raw,
	input logic linear_a_enabled,
	input logic linear_a_invalid_raw,
	input logic linear_a_limit_raw,
	input logic linear_a_short_raw,
	// Load measurement logic, same clock
	input logic load_measure_done,
	// Open-drain interrupt pin, low enable pulls pin low
	output logic interrupt_out_low_oe_n
);
	import pmic_status_pkg::*;

	localparam int CNT_W = $clog2(SHORT_LIMIT + 1);
	localparam logic [CNT_W-1:0] CNT_END = CNT_W'(SHORT_LIMIT);

	typedef struct packed {
		logic [23:0] sync1_stat;
		logic [23:0] sync2_stat;
		logic [23:0] prev_stat;
		logic [3:0] sync1_short;
		logic [3:0] sync2_short;
		logic [3:0][CNT_W-1:0] short_cnt;
		logic [7:0] top_event;
		logic rst_event;
		logic [7:0] sw_event;
		logic [7:0] lin_event;
		logic [7:0] top_mask_one;
		logic top_mask_two;
		logic [7:0] sw_mask;
		logic [7:0] rdata;
		logic irq_oe_n;
	} state_t;

	state_t q;
	state_t next_q;

	logic [23:0] raw_stat;
	logic [3:0] raw_short;
	logic [7:0] top_now;
	logic [7:0] sw_now;
	logic [7:0] lin_now;
	logic [7:0] top_was;
	logic [7:0] sw_was;
	logic [7:0] lin_was;
	logic [7:0] top_set;
	logic [7:0] sw_set;
	logic [7:0] lin_set;
	logic [3:0] short_hit;
	logic [7:0] top_view;
	logic pending;

	// ****************************************
	// Monitor inputs gathered in status-register order
	// ****************************************
	assign raw_stat = {power_good_output, 2'b00, external_clock_invalid,
		thermal_shutdown_state, thermal_warning_state,
		input_overvoltage_state, 1'b0,
		switcher_b_enabled, switcher_b_invalid_raw, 1'b0,
		switcher_b_limit_raw, switcher_a_enabled,
		switcher_a_invalid_raw, 1'b0, switcher_a_limit_raw,
		linear_b_enabled, linear_b_invalid_raw, 1'b0,
		linear_b_limit_raw, linear_a_enabled,
		linear_a_invalid_raw, 1'b0, linear_a_limit_raw};
	// Order: linear a, linear b, switcher a, switcher b
	assign raw_short = {switcher_b_short_raw, switcher_a_short_raw,
		linear_b_short_raw, linear_a_short_raw};

	assign top_now = q.sync2_stat[23:16] & TOP_STATUS_USED;
	assign sw_now = q.sync2_stat[15:8] & REG_STATUS_USED;
	assign lin_now = q.sync2_stat[7:0] & REG_STATUS_USED;
	assign top_was = q.prev_stat[23:16];
	assign sw_was = q.prev_stat[15:8];
	assign lin_was = q.prev_stat[7:0];

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_q = q;
		top_set = 8'h00;
		sw_set = 8'h00;
		lin_set = 8'h00;
		short_hit = 4'h0;
		top_view = 8'h00;
		pending = 1'b0;

		// Two-stage synchronisers
		next_q.sync1_stat = raw_stat;
		next_q.sync2_stat = q.sync1_stat;
		next_q.sync1_short = raw_short;
		next_q.sync2_short = q.sync1_short;
		next_q.prev_stat = q.sync2_stat;

		// Short must persist past the full time
		for (int i = 0; i < 4; i++) begin
			if (!q.sync2_short[i]) begin
				next_q.short_cnt[i] = '0;
			end else if (q.short_cnt[i] != CNT_END) begin
				next_q.short_cnt[i] = q.short_cnt[i] + 1'b1;
			end else begin
				short_hit[i] = 1'b1;
			end
		end

		// Top-level events
		top_set[POS_PG] = top_was[POS_PG] & ~top_now[POS_PG];
		top_set[POS_CLK] = top_was[POS_CLK] ^ top_now[POS_CLK];
		top_set[POS_SD] = ~top_was[POS_SD] & top_now[POS_SD];
		top_set[POS_WARN] = ~top_was[POS_WARN] & top_now[POS_WARN];
		top_set[POS_OVP] = ~top_was[POS_OVP] & top_now[POS_OVP];
		top_set[POS_MEAS] = load_measure_done;

		// Switcher and linear events; switcher good event only for an unmasked direction
		for (int g = 0; g < 2; g++) begin
			int b;
			b = (g == 0) ? BASE_A : BASE_B;
			sw_set[b + OFF_INV] =
				(~sw_was[b + OFF_INV] & sw_now[b + OFF_INV] &
				~q.sw_mask[b + OFF_FALL_GATE]) |
				(sw_was[b + OFF_INV] & ~sw_now[b + OFF_INV] &
				~q.sw_mask[b + OFF_INV]);
			sw_set[b + OFF_SHORT] = short_hit[2 + g];
			sw_set[b + OFF_LIM] = sw_now[b + OFF_LIM];
			lin_set[b + OFF_INV] =
				lin_was[b + OFF_INV] ^ lin_now[b + OFF_INV];
			lin_set[b + OFF_SHORT] = short_hit[g];
			lin_set[b + OFF_LIM] = lin_now[b + OFF_LIM];
		end

		// Flags: a set in the clearing cycle wins
		next_q.top_event = q.top_event | top_set;
		next_q.sw_event = q.sw_event | sw_set;
		next_q.lin_event = q.lin_event | lin_set;
		if (reg_write) begin
			case (reg_addr)
				ADDR_TOP_EVENT: begin
					next_q.top_event = (q.top_event &
						~(reg_wdata & TOP_EVENT_CLEARABLE)) | top_set;
				end
				ADDR_TOP_EVENT_TWO: begin
					if (reg_wdata[POS_RST_EVT]) begin
						next_q.rst_event = 1'b0;
					end
				end
				ADDR_SW_EVENT: begin
					next_q.sw_event = (q.sw_event &
						~(reg_wdata & REG_EVENT_CLEARABLE)) | sw_set;
				end
				ADDR_LIN_EVENT: begin
					next_q.lin_event = (q.lin_event &
						~(reg_wdata & REG_EVENT_CLEARABLE)) |
						lin_set;
				end
				ADDR_TOP_MASK_ONE: begin
					next_q.top_mask_one = reg_wdata & TOP_MASK_ONE_WRITABLE;
				end
				ADDR_SW_MASK: begin
					next_q.sw_mask = reg_wdata & SW_MASK_WRITABLE;
				end
				// Mask two and status offsets keep their value
				default: begin
					next_q.top_mask_two = q.top_mask_two;
				end
			endcase
		end

		// Top event view with live summaries
		top_view = q.top_event & TOP_EVENT_CLEARABLE;
		top_view[POS_LIN_SUM] = |q.lin_event;
		top_view[POS_SW_SUM] = |q.sw_event;

		// Read data captured on the read strobe
		if (reg_read) begin
			case (reg_addr)
				ADDR_TOP_EVENT: next_q.rdata = top_view;
				ADDR_TOP_EVENT_TWO: next_q.rdata = {7'h00, q.rst_event};
				ADDR_SW_EVENT: next_q.rdata = q.sw_event;
				ADDR_LIN_EVENT: next_q.rdata = q.lin_event;
				ADDR_TOP_STATUS: begin
					next_q.rdata = top_now;
				end
				ADDR_SW_STATUS: begin
					next_q.rdata = sw_now;
				end
				ADDR_LIN_STATUS: begin
					next_q.rdata = lin_now;
				end
				ADDR_TOP_MASK_ONE: next_q.rdata = q.top_mask_one;
				ADDR_TOP_MASK_TWO: next_q.rdata = {7'h00, q.top_mask_two};
				ADDR_SW_MASK: next_q.rdata = q.sw_mask;
				default: next_q.rdata = 8'h00;
			endcase
		end

		// Unmasked pending flags pull the pin low
		pending =
			(q.top_event[POS_PG] & ~q.top_mask_one[POS_PG]) |
			(q.top_event[POS_CLK] & ~q.top_mask_one[POS_CLK]) |
			(q.top_event[POS_WARN] & ~q.top_mask_one[POS_WARN]) |
			(q.top_event[POS_MEAS] & ~q.top_mask_one[POS_MEAS]) |
			q.top_event[POS_SD] | q.top_event[POS_OVP] |
			(q.rst_event & ~q.top_mask_two) |
			(q.sw_event[BASE_B + OFF_LIM] &
			~q.sw_mask[BASE_B + OFF_LIM]) |
			(q.sw_event[BASE_A + OFF_LIM] & ~q.sw_mask[BASE_A + OFF_LIM]) |
			q.sw_event[BASE_B + OFF_INV] | q.sw_event[BASE_A + OFF_INV] |
			q.sw_event[BASE_B + OFF_SHORT] | q.sw_event[BASE_A + OFF_SHORT] |
			(|q.lin_event);
		next_q.irq_oe_n = ~pending;
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= '0;
			q.top_event <= EVENT_RESET;
			q.sw_event <= EVENT_RESET;
			q.lin_event <= EVENT_RESET;
			q.rst_event <= RST_EVT_RESET;
			q.top_mask_one <= otp_top_mask_one & TOP_MASK_ONE_USED;
			q.top_mask_two <= otp_top_mask_two;
			q.sw_mask <= otp_switcher_mask & SW_MASK_WRITABLE;
			q.rdata <= RDATA_RESET;
			q.irq_oe_n <= 1'b1;
		end else if (ce) begin
			q <= next_q;
		end
	end

	assign reg_rdata = q.rdata;
	assign interrupt_out_low_oe_n = q.irq_oe_n;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	chk_lin_good_set: assert property (
		(ce && lin_set[BASE_A + OFF_INV]) |=> q.lin_event[BASE_A + OFF_INV])
		else $error("linear_a good event lost");

	chk_lin_short_time: assert property (
		$rose(q.lin_event[BASE_A + OFF_SHORT]) |->
		$past(q.short_cnt[0]) == CNT_END && $past(q.sync2_short[0]))
		else $error("linear_a short flag set early");

	chk_lin_limit_clear: assert property (
		(ce && reg_write && reg_addr == ADDR_LIN_EVENT &&
		reg_wdata[BASE_A + OFF_LIM] && !lin_set[BASE_A + OFF_LIM])
		|=> !q.lin_event[BASE_A + OFF_LIM])
		else $error("linear_a limit flag not cleared");

	chk_top_status_read: assert property (
		(ce && reg_read && reg_addr == ADDR_TOP_STATUS) |=>
		reg_rdata == ($past(q.sync2_stat[23:16]) & 8'h9e))
		else $error("top status read wrong");

	chk_reg_status_read: assert property (
		(ce && reg_read && reg_addr == ADDR_LIN_STATUS) |=>
		reg_rdata == ($past(q.sync2_stat[7:0]) & 8'hdd))
		else $error("linear status read wrong");

	chk_mask_two_hold: assert property (
		(ce && reg_write && reg_addr == ADDR_TOP_MASK_TWO) |=>
		$stable(q.top_mask_two))
		else $error("mask two changed by write");

	chk_fall_gate: assert property (
		(ce && q.sw_mask[BASE_B + OFF_FALL_GATE] &&
		!sw_was[BASE_B + OFF_INV] && sw_now[BASE_B + OFF_INV] &&
		!q.sw_event[BASE_B + OFF_INV]) |=> !q.sw_event[BASE_B + OFF_INV])
		else $error("masked fall raised event");

	chk_rise_gate: assert property (
		(ce && q.sw_mask[BASE_A + OFF_INV] &&
		sw_was[BASE_A + OFF_INV] && !sw_now[BASE_A + OFF_INV] &&
		!q.sw_event[BASE_A + OFF_INV]) |=> !q.sw_event[BASE_A + OFF_INV])
		else $error("masked rise raised event");

	chk_summary_read: assert property (
		(ce && reg_read && reg_addr == ADDR_TOP_EVENT) |=>
		reg_rdata[POS_LIN_SUM] == $past(|q.lin_event))
		else $error("linear summary mismatch");

	chk_pg_event: assert property (
		(ce && top_was[POS_PG] && !top_now[POS_PG]) |=> q.top_event[POS_PG])
		else $error("power good fall not latched");

	chk_clk_event: assert property (
		(ce && top_was[POS_CLK] != top_now[POS_CLK]) |=>
		q.top_event[POS_CLK])
		else $error("clock change not latched");

	chk_irq_level: assert property (
		($past(ce) && !$past(rst)) |->
		interrupt_out_low_oe_n == !$past(pending))
		else $error("interrupt pin level wrong");

	cov_short_event: cover property (ce && short_hit[0]);
	cov_irq_assert: cover property ($fell(interrupt_out_low_oe_n));
	cov_set_on_clear: cover property (ce && reg_write &&
		reg_addr == ADDR_LIN_EVENT && |(reg_wdata & lin_set));
	cov_irq_release: cover property ($rose(interrupt_out_low_oe_n));
endmodule

//--- pmic_status_event_mask_tb.sv
// Self-checking testbench for the status, event and mask block
`timescale 1ns/1ns
module pmic_status_event_mask_tb;
	import pmic_status_pkg::*;

	localparam int SHORT_SIM = 8;
	logic mclk;
	logic rst;
	logic ce;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic [7:0] reg_rdata;
	logic [7:0] otp_one;
	logic otp_two;
	logic [7:0] otp_sw;
	logic [20:0] mon;
	logic meas_done;
	logic oe_n;
	int errors;
	int comparisons;
	int st_idx[17] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 10, 11, 13, 14, 15,
		17, 18, 19};
	int st_reg[17] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2};
	int st_bit[17] = '{7, 4, 3, 2, 1, 7, 6, 4, 3, 2, 0, 7, 6, 4, 3, 2, 0};
	int top_bit[4] = '{7, 4, 2, 0};

	pmic_status_event_mask #(.SHORT_LIMIT(SHORT_SIM)) u_dut (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.otp_top_mask_one(otp_one),
		.otp_top_mask_two(otp_two),
		.otp_switcher_mask(otp_sw),
		.power_good_output(mon[0]),
		.external_clock_invalid(mon[1]),
		.thermal_shutdown_state(mon[2]),
		.thermal_warning_state(mon[3]),
		.input_overvoltage_state(mon[4]),
		.switcher_b_enabled(mon[5]),
		.switcher_b_invalid_raw(mon[6]),
		.switcher_b_limit_raw(mon[7]),
		.switcher_b_short_raw(mon[8]),
		.switcher_a_enabled(mon[9]),
		.switcher_a_invalid_raw(mon[10]),
		.switcher_a_limit_raw(mon[11]),
		.switcher_a_short_raw(mon[12]),
		.linear_b_enabled(mon[13]),
		.linear_b_invalid_raw(mon[14]),
		.linear_b_limit_raw(mon[15]),
		.linear_b_short_raw(mon[16]),
		.linear_a_enabled(mon[17]),
		.linear_a_invalid_raw(mon[18]),
		.linear_a_limit_raw(mon[19]),
		.linear_a_short_raw(mon[20]),
		.load_measure_done(meas_done),
		.interrupt_out_low_oe_n(oe_n)
	);

	reg_host_model u_host (
		.mclk(mclk),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata)
	);

	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic finish_test();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic check_pin(input logic exp);
		comparisons++;
		if (oe_n !== exp) begin
			errors++;
			$display("unexpected at %0t: pin enable %b", $time, oe_n);
		end
	endtask

	task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] got;
		u_host.read_reg(addr, got);
		check_reg(got, exp);
	endtask

	task automatic clear_events();
		u_host.write_reg(ADDR_TOP_EVENT, 8'hff);
		u_host.write_reg(ADDR_TOP_EVENT_TWO, 8'hff);
		u_host.write_reg(ADDR_SW_EVENT, 8'hff);
		u_host.write_reg(ADDR_LIN_EVENT, 8'hff);
		wait_cyc(2);
	endtask

	// Makes one top-level event of kind s
	task automatic cause_top(input int s);
		case (s)
			0: begin
				mon[0] = 1'b1;
				wait_cyc(4);
				mon[0] = 1'b0;
			end
			1: mon[1] = ~mon[1];
			2: begin
				mon[3] = 1'b1;
				wait_cyc(4);
				mon[3] = 1'b0;
			end
			default: begin
				meas_done = 1'b1;
				wait_cyc(1);
				meas_done = 1'b0;
			end
		endcase
	endtask

	// Raises each monitor in turn and reads its live status bit
	task automatic probe_status(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			mon[st_idx[i]] = 1'b1;
			wait_cyc(4);
			expect_reg(ADDR_TOP_STATUS + 8'(st_reg[i]), 8'h01 << st_bit[i]);
			mon[st_idx[i]] = 1'b0;
			wait_cyc(4);
		end
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		finish_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [7:0] exp;
		errors = 0;
		comparisons = 0;
		rst = 1'b1;
		ce = 1'b1;
		otp_one = 8'hff;
		otp_two = 1'b0;
		otp_sw = 8'hff;
		mon = '0;
		meas_done = 1'b0;
		repeat (20) @(posedge mclk);
		#1;
		rst = 1'b0;
		wait_cyc(3);
		check_pin(1'b0);
		expect_reg(ADDR_TOP_MASK_ONE, 8'h95);
		expect_reg(ADDR_SW_MASK, 8'hdd);
		u_host.write_reg(ADDR_TOP_MASK_TWO, 8'h01);
		expect_reg(ADDR_TOP_MASK_TWO, 8'h00);
		u_host.write_reg(ADDR_TOP_EVENT_TWO, 8'h01);
		wait_cyc(2);
		check_pin(1'b1);
		u_host.write_reg(ADDR_TOP_STATUS, 8'hff);
		expect_reg(ADDR_TOP_STATUS, 8'h00);
		expect_reg(8'h30, 8'h00);
		// Live status, one monitor at a time
		probe_status(0, 4);
		probe_status(5, 10);
		probe_status(11, 16);
		clear_events();
		check_pin(1'b1);
		// Linear event flags and summary
		mon[19] = 1'b1;
		wait_cyc(3);
		mon[19] = 1'b0;
		wait_cyc(4);
		expect_reg(ADDR_LIN_EVENT, 8'h01);
		expect_reg(ADDR_TOP_EVENT, 8'h40);
		check_pin(1'b0);
		mon[20] = 1'b1;
		wait_cyc(SHORT_SIM - 2);
		mon[20] = 1'b0;
		wait_cyc(4);
		expect_reg(ADDR_LIN_EVENT, 8'h01);
		mon[20] = 1'b1;
		wait_cyc(SHORT_SIM + 6);
		mon[20] = 1'b0;
		mon[18] = 1'b1;
		wait_cyc(4);
		expect_reg(ADDR_LIN_EVENT, 8'h07);
		u_host.write_reg(ADDR_LIN_EVENT, 8'h05);
		expect_reg(ADDR_LIN_EVENT, 8'h02);
		mon[18] = 1'b0;
		wait_cyc(4);
		expect_reg(ADDR_LIN_EVENT, 8'h06);
		u_host.write_reg(ADDR_LIN_EVENT, 8'h06);
		wait_cyc(2);
		expect_reg(ADDR_TOP_EVENT, 8'h00);
		check_pin(1'b1);
		// Top-level events with mask open and closed
		for (int s = 0; s < 4; s++) begin
			for (int m = 0; m < 2; m++) begin
				u_host.write_reg(ADDR_TOP_MASK_ONE, 8'(m) << top_bit[s]);
				cause_top(s);
				wait_cyc(5);
				check_pin(m == 1);
				exp = 8'h01 << top_bit[s];
				expect_reg(ADDR_TOP_EVENT, exp);
				u_host.write_reg(ADDR_TOP_EVENT, 8'hff);
				wait_cyc(2);
				check_pin(1'b1);
			end
		end
		// Switcher direction gates and limit gate
		u_host.write_reg(ADDR_SW_MASK, 8'h04);
		mon[10] = 1'b1;
		wait_cyc(4);
		expect_reg(ADDR_SW_EVENT, 8'h04);
		u_host.write_reg(ADDR_SW_EVENT, 8'hff);
		mon[10] = 1'b0;
		wait_cyc(4);
		expect_reg(ADDR_SW_EVENT, 8'h00);
		u_host.write_reg(ADDR_SW_MASK, 8'h08);
		mon[10] = 1'b1;
		wait_cyc(4);
		expect_reg(ADDR_SW_EVENT, 8'h00);
		mon[10] = 1'b0;
		wait_cyc(4);
		expect_reg(ADDR_SW_EVENT, 8'h04);
		u_host.write_reg(ADDR_SW_MASK, 8'h01);
		u_host.write_reg(ADDR_SW_EVENT, 8'hff);
		mon[11] = 1'b1;
		wait_cyc(2);
		mon[11] = 1'b0;
		wait_cyc(4);
		check_pin(1'b1);
		expect_reg(ADDR_SW_EVENT, 8'h01);
		u_host.write_reg(ADDR_SW_MASK, 8'h00);
		wait_cyc(3);
		check_pin(1'b0);
		clear_events();
		check_pin(1'b1);
		u_host.write_reg(ADDR_SW_MASK, 8'hff);
		expect_reg(ADDR_SW_MASK, 8'hdd);
		// Enable low: monitor change and mask write are both ignored
		ce = 1'b0;
		mon[19] = 1'b1;
		u_host.write_reg(ADDR_TOP_MASK_ONE, 8'h00);
		wait_cyc(4);
		mon[19] = 1'b0;
		wait_cyc(4);
		ce = 1'b1;
		check_pin(1'b1);
		expect_reg(ADDR_LIN_EVENT, 8'h00);
		expect_reg(ADDR_TOP_MASK_ONE, 8'h01);
		// Reset in mid-run reloads masks; reset event now masked
		otp_two = 1'b1;
		otp_one = 8'h00;
		rst = 1'b1;
		wait_cyc(2);
		rst = 1'b0;
		wait_cyc(3);
		check_pin(1'b1);
		expect_reg(ADDR_TOP_EVENT_TWO, 8'h01);
		expect_reg(ADDR_TOP_MASK_TWO, 8'h01);
		expect_reg(ADDR_TOP_MASK_ONE, 8'h00);
		u_host.write_reg(ADDR_TOP_MASK_TWO, 8'h00);
		expect_reg(ADDR_TOP_MASK_TWO, 8'h01);
		finish_test();
	end
endmodule

//--- pmic_status_pkg.sv
// Register map, field positions, reset values and timing for status block
package pmic_status_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_TOP_EVENT = 8'h19;
	localparam logic [7:0] ADDR_TOP_EVENT_TWO = 8'h1a;
	localparam logic [7:0] ADDR_SW_EVENT = 8'h1b;
	localparam logic [7:0] ADDR_LIN_EVENT = 8'h1c;
	localparam logic [7:0] ADDR_TOP_STATUS = 8'h1d;
	localparam logic [7:0] ADDR_SW_STATUS = 8'h1e;
	localparam logic [7:0] ADDR_LIN_STATUS = 8'h1f;
	localparam logic [7:0] ADDR_TOP_MASK_ONE = 8'h20;
	localparam logic [7:0] ADDR_TOP_MASK_TWO = 8'h21;
	localparam logic [7:0] ADDR_SW_MASK = 8'h22;

	// ****************************************
	// Top-level field positions
	// ****************************************
	localparam int POS_PG = 7;
	localparam int POS_LIN_SUM = 6;
	localparam int POS_SW_SUM = 5;
	localparam int POS_CLK = 4;
	localparam int POS_SD = 3;
	localparam int POS_WARN = 2;
	localparam int POS_OVP = 1;
	localparam int POS_MEAS = 0;
	localparam int POS_RST_EVT = 0;

	// ****************************************
	// Per-regulator group: base of b and a, offsets inside a group
	// ****************************************
	localparam int BASE_B = 4;
	localparam int BASE_A = 0;
	localparam int OFF_EN = 3;
	localparam int OFF_FALL_GATE = 3;
	localparam int OFF_INV = 2;
	localparam int OFF_SHORT = 1;
	localparam int OFF_LIM = 0;

	// ****************************************
	// Writable, clearable and readable bit sets
	// ****************************************
	localparam logic [7:0] TOP_EVENT_CLEARABLE = 8'h9f;
	localparam logic [7:0] REG_EVENT_CLEARABLE = 8'h77;
	localparam logic [7:0] TOP_MASK_ONE_WRITABLE = 8'hff;
	localparam logic [7:0] TOP_MASK_ONE_USED = 8'h95;
	localparam logic [7:0] SW_MASK_WRITABLE = 8'hdd;
	localparam logic [7:0] TOP_STATUS_USED = 8'h9e;
	localparam logic [7:0] REG_STATUS_USED = 8'hdd;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] EVENT_RESET = 8'h00;
	localparam logic RST_EVT_RESET = 1'b1;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ = 25;
	localparam int SHORT_TIME_US = 1000;
	localparam int SHORT_CYCLES = SHORT_TIME_US * CLK_MHZ;

endpackage

//--- reg_host_model.sv
// Host-side model that issues register reads and writes on the strobe port
`timescale 1ns/1ns
module reg_host_model (
	// Clock
	input logic mclk,
	// Register port towards the block
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	output logic reg_read,
	input logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end

	// One whole 8-bit register per strobe; idle lines show inverted values
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge mclk);
		#1;
		reg_addr = addr;
		reg_wdata = data;
		reg_write = 1'b1;
		@(posedge mclk);
		#1;
		reg_write = 1'b0;
		reg_addr = ~addr;
		reg_wdata = ~data;
	endtask

	// Data is taken one edge after the strobe edge, once settled
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge mclk);
		#1;
		reg_addr = addr;
		reg_read = 1'b1;
		@(posedge mclk);
		#1;
		reg_read = 1'b0;
		reg_addr = ~addr;
		@(posedge mclk);
		#1;
		data = reg_rdata;
	endtask
endmodule
